// File: rtl/lbb_exec.sv
// Execution slice for AND-with-literal, AND-with-file, bit clear and the
// carry and negative conditional branches, with an APB register front end.
// Assumes one 50 MHz clock, an asynchronous active-low reset and an APB
// master that issues one instruction at a time through the issue register.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module lbb_exec
	import lbb_pkg::*;
#(
	parameter int LBB_ADDR_W = 12, // Data memory address width.
	parameter int LBB_PC_W   = 21  // Program counter width.
)(
	// Clock and reset.
	input  wire logic        ref_clk_in,
	input  wire logic        arst_n_in,
	// APB slave.
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);
	import lbb_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [7:0]            mem_reg [2**LBB_ADDR_W]; // Data memory.
	lbb_state_t            state_reg;               // Sequencer state.
	logic [1:0]            phase_reg;               // Clock phase within a cycle.
	logic [15:0]           instr_reg;               // Instruction being run.
	logic [7:0]            w_reg;                   // Working register.
	logic [3:0]            bank_reg;                // Bank select register.
	logic [7:0]            flags_reg;               // Status flags.
	logic [LBB_PC_W-1:0]   pc_reg;                  // Program counter.
	logic [LBB_ADDR_W-1:0] index_reg;               // Indexed offset base.
	logic [LBB_ADDR_W-1:0] maddr_reg;               // Memory window address.
	logic                  ext_reg;                 // Extended set enabled.
	logic                  illegal_reg;             // Opcode outside slice.
	logic [1:0]            cyc_reg;                 // Instruction cycles used.
	logic [7:0]            operand_reg;             // Value read in phase two.
	logic [7:0]            result_reg;              // Value formed in phase three.
	logic                  taken_reg;               // Branch decided taken.
	logic [LBB_ADDR_W-1:0] daddr_reg;               // Resolved data address.

	// ------------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------------
	logic is_and_lit;  // AND with literal.
	logic is_and_file; // AND with file register.
	logic is_bit_clr;  // Bit clear.
	logic is_br_carry; // Branch on carry.
	logic is_br_neg;   // Branch on negative.
	logic run_q1;      // Decode phase strobe.
	logic run_q2;      // Read phase strobe.
	logic run_q3;      // Process phase strobe.
	logic run_q4;      // Write phase strobe.

	assign is_and_lit  = instr_reg[15:8] == LBB_OP_AND_LIT;
	assign is_and_file = instr_reg[15:10] == LBB_OP_AND_FILE;
	assign is_bit_clr  = instr_reg[15:12] == LBB_OP_BIT_CLR;
	assign is_br_carry = instr_reg[15:8] == LBB_OP_BR_CARRY;
	assign is_br_neg   = instr_reg[15:8] == LBB_OP_BR_NEG;
	assign run_q1 = (state_reg == LBB_RUN) && (phase_reg == 2'h0);
	assign run_q2 = (state_reg == LBB_RUN) && (phase_reg == 2'h1);
	assign run_q3 = (state_reg == LBB_RUN) && (phase_reg == 2'h2);
	assign run_q4 = (state_reg == LBB_RUN) && (phase_reg == LBB_PHASE_LAST);

	// Resolve the 8-bit file field to a data memory address.
	function automatic logic [LBB_ADDR_W-1:0] lbb_resolve(
		input logic [7:0] f, input logic a, input logic ext,
		input logic [3:0] bank, input logic [LBB_ADDR_W-1:0] base);
		logic [LBB_ADDR_W-1:0] addr;
		addr = '0;
		if (a)
			addr = LBB_ADDR_W'({bank, f});
		else if (ext && (f <= LBB_ACCESS_SPLIT))
			addr = base + LBB_ADDR_W'(f);
		else if (f <= LBB_ACCESS_SPLIT)
			addr = LBB_ADDR_W'(f);
		else
			addr = LBB_ADDR_W'({LBB_ACCESS_HIGH, f});
		return addr;
	endfunction

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic apb_wr;    // Write access phase.
	logic map_hit;   // Address lands on a register.
	logic issue;     // Instruction issue accepted.

	always_comb
	begin
		unique case (paddr_in)
			LBB_OFS_CTRL, LBB_OFS_INSTR, LBB_OFS_WREG, LBB_OFS_BANK,
			LBB_OFS_FLAGS, LBB_OFS_PC, LBB_OFS_INDEX, LBB_OFS_MADDR,
			LBB_OFS_MDATA, LBB_OFS_XSTAT: map_hit = 1'b1;
			default: map_hit = 1'b0;
		endcase
	end

	// Zero wait state; unmapped addresses answer with an error.
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in && penable_in && !map_hit;
	// Core writes are refused while an instruction runs so state is coherent.
	assign apb_wr = psel_in && penable_in && pwrite_in && (state_reg == LBB_IDLE);
	assign issue  = apb_wr && (paddr_in == LBB_OFS_INSTR);

	// Read data is a register: captured in setup, stable in access phase.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			prdata_out <= 32'h0000_0000;
		else if (psel_in && !penable_in && !pwrite_in)
		begin
			unique case (paddr_in)
				LBB_OFS_CTRL:  prdata_out <= 32'(ext_reg);
				LBB_OFS_INSTR: prdata_out <= 32'(instr_reg);
				LBB_OFS_WREG:  prdata_out <= 32'(w_reg);
				LBB_OFS_BANK:  prdata_out <= 32'(bank_reg);
				LBB_OFS_FLAGS: prdata_out <= 32'(flags_reg);
				LBB_OFS_PC:    prdata_out <= 32'(pc_reg);
				LBB_OFS_INDEX: prdata_out <= 32'(index_reg);
				LBB_OFS_MADDR: prdata_out <= 32'(maddr_reg);
				LBB_OFS_MDATA: prdata_out <= 32'(mem_reg[maddr_reg]);
				LBB_OFS_XSTAT: prdata_out <= 32'({cyc_reg, 2'b00, illegal_reg,
					state_reg != LBB_IDLE});
				default:       prdata_out <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	// Each instruction cycle is four clocks; a taken branch adds a flush.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_reg <= LBB_IDLE;
			phase_reg <= 2'h0;
		end
		else
		begin
			unique case (state_reg)
				LBB_IDLE:
				begin
					phase_reg <= 2'h0;
					if (issue)
						state_reg <= LBB_RUN;
				end
				LBB_RUN:
				begin
					phase_reg <= phase_reg + 2'h1;
					if (phase_reg == LBB_PHASE_LAST)
						state_reg <= taken_reg ? LBB_FLUSH : LBB_IDLE;
				end
				LBB_FLUSH:
				begin
					// The refill cycle does nothing but let the new fetch land.
					phase_reg <= phase_reg + 2'h1;
					if (phase_reg == LBB_PHASE_LAST)
						state_reg <= LBB_IDLE;
				end
				default:
					state_reg <= LBB_IDLE;
			endcase
		end
	end

	// Instruction latch, cycle count and illegal flag.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			instr_reg   <= 16'h0000;
			cyc_reg     <= 2'h0;
			illegal_reg <= 1'b0;
		end
		else if (issue)
		begin
			instr_reg <= pwdata_in[15:0];
			cyc_reg   <= 2'h1;
		end
		else if (run_q1)
			illegal_reg <= !(is_and_lit || is_and_file || is_bit_clr ||
				is_br_carry || is_br_neg);
		else if (run_q4 && taken_reg)
			cyc_reg <= 2'h2;
	end

	// ------------------------------------------------------------------
	// Datapath by phase
	// ------------------------------------------------------------------
	// Phase one decodes the address; phase two reads; phase three processes.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			daddr_reg   <= '0;
			operand_reg <= 8'h00;
			result_reg  <= 8'h00;
			taken_reg   <= 1'b0;
		end
		else if (run_q1)
		begin
			taken_reg <= 1'b0;
			daddr_reg <= lbb_resolve(instr_reg[7:0], instr_reg[8], ext_reg,
				bank_reg, index_reg);
		end
		else if (run_q2)
			operand_reg <= is_and_lit ? instr_reg[7:0] : mem_reg[daddr_reg];
		else if (run_q3)
		begin
			if (is_bit_clr)
				result_reg <= operand_reg & ~(8'h01 << instr_reg[11:9]);
			else
				result_reg <= w_reg & operand_reg;
			taken_reg <= (is_br_carry && flags_reg[LBB_FLAG_C_BIT]) ||
				(is_br_neg && flags_reg[LBB_FLAG_N_BIT]);
		end
	end

	// Working register: software load when idle, or AND result in phase four.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			w_reg <= 8'h00;
		else if (run_q4 && (is_and_lit || (is_and_file && !instr_reg[9])))
			w_reg <= result_reg;
		else if (apb_wr && paddr_in == LBB_OFS_WREG)
			w_reg <= pwdata_in[7:0];
	end

	// Status flags: only the AND operations touch N and Z.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			flags_reg <= 8'h00;
		else if (run_q4 && (is_and_lit || is_and_file))
		begin
			flags_reg[LBB_FLAG_N_BIT] <= result_reg[7];
			flags_reg[LBB_FLAG_Z_BIT] <= result_reg == 8'h00;
		end
		else if (apb_wr && paddr_in == LBB_OFS_FLAGS)
			flags_reg <= pwdata_in[7:0];
	end

	// Program counter: stepped in decode, branch target written in phase four.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pc_reg <= '0;
		else if (run_q1)
			pc_reg <= pc_reg + LBB_PC_W'(LBB_PC_STEP);
		else if (run_q4 && taken_reg)
			// The offset in words becomes bytes by a left shift
			pc_reg <= pc_reg + LBB_PC_W'({{(LBB_PC_W-9){instr_reg[7]}},
				instr_reg[7:0], 1'b0});
		else if (apb_wr && paddr_in == LBB_OFS_PC)
			pc_reg <= pwdata_in[LBB_PC_W-1:0] & ~LBB_PC_W'(1);
	end

	// Data memory: file results in phase four, window writes when idle.
	always_ff @(posedge ref_clk_in)
	begin
		if (run_q4 && (is_bit_clr || (is_and_file && instr_reg[9])))
			mem_reg[daddr_reg] <= result_reg;
		else if (apb_wr && paddr_in == LBB_OFS_MDATA)
			mem_reg[maddr_reg] <= pwdata_in[7:0];
	end

	// Software-only configuration registers.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			ext_reg   <= 1'b0;
			bank_reg  <= 4'h0;
			index_reg <= '0;
			maddr_reg <= '0;
		end
		else if (apb_wr)
		begin
			unique case (paddr_in)
				LBB_OFS_CTRL:  ext_reg   <= pwdata_in[LBB_CTRL_EXT_BIT];
				LBB_OFS_BANK:  bank_reg  <= pwdata_in[3:0];
				LBB_OFS_INDEX: index_reg <= pwdata_in[LBB_ADDR_W-1:0];
				LBB_OFS_MADDR: maddr_reg <= pwdata_in[LBB_ADDR_W-1:0];
				default:       ext_reg   <= ext_reg;
			endcase
		end
	end

endmodule // lbb_exec

// File: rtl/lbb_pkg.sv
// Constants shared by the bit-clear, AND and branch execution slice.
// Assumes a single 50 MHz clock and an APB master with 32-bit data.
package lbb_pkg;
	// ------------------------------------------------------------------
	// Register byte offsets on APB
	// ------------------------------------------------------------------
	localparam logic [7:0] LBB_OFS_CTRL   = 8'h00; // Mode control.
	localparam logic [7:0] LBB_OFS_INSTR  = 8'h04; // Instruction issue.
	localparam logic [7:0] LBB_OFS_WREG   = 8'h08; // Working register.
	localparam logic [7:0] LBB_OFS_BANK   = 8'h0c; // Bank select register.
	localparam logic [7:0] LBB_OFS_FLAGS  = 8'h10; // Status flags.
	localparam logic [7:0] LBB_OFS_PC     = 8'h14; // Program counter.
	localparam logic [7:0] LBB_OFS_INDEX  = 8'h18; // Indexed offset base.
	localparam logic [7:0] LBB_OFS_MADDR  = 8'h1c; // Memory window address.
	localparam logic [7:0] LBB_OFS_MDATA  = 8'h20; // Memory window data.
	localparam logic [7:0] LBB_OFS_XSTAT  = 8'h24; // Execution status.
	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int LBB_CTRL_EXT_BIT  = 0; // Extended instruction set on.
	localparam int LBB_FLAG_C_BIT    = 0; // Carry flag.
	localparam int LBB_FLAG_Z_BIT    = 2; // Zero flag.
	localparam int LBB_FLAG_N_BIT    = 4; // Negative flag.
	localparam int LBB_XSTAT_BUSY    = 0; // Instruction in progress.
	localparam int LBB_XSTAT_ILLEGAL = 1; // Last opcode not in this slice.
	localparam int LBB_XSTAT_CYC_LSB = 4; // Cycles of last instruction.
	// ------------------------------------------------------------------
	// Opcode patterns
	// ------------------------------------------------------------------
	localparam logic [7:0] LBB_OP_AND_LIT = 8'h0b; // 0000 1011 kkkk kkkk.
	localparam logic [5:0] LBB_OP_AND_FILE = 6'h05; // 0001 01da ffff ffff.
	localparam logic [3:0] LBB_OP_BIT_CLR = 4'h9; // 1001 bbba ffff ffff.
	localparam logic [7:0] LBB_OP_BR_CARRY = 8'he2; // 1110 0010 nnnn nnnn.
	localparam logic [7:0] LBB_OP_BR_NEG  = 8'he6; // 1110 0110 nnnn nnnn.
	// ------------------------------------------------------------------
	// Addressing and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] LBB_ACCESS_SPLIT = 8'h5f; // Last low access/indexed address.
	localparam logic [3:0] LBB_ACCESS_HIGH  = 4'hf;  // Bank of upper access half.
	localparam logic [1:0] LBB_PC_STEP      = 2'h2;  // Bytes per instruction word.
	localparam logic [1:0] LBB_PHASE_LAST   = 2'h3;  // Fourth clock phase.
	// Execution sequencer states, Gray coded along idle, run, flush.
	typedef enum logic [1:0] {
		LBB_IDLE  = 2'b00,
		LBB_RUN   = 2'b01,
		LBB_FLUSH = 2'b11
	} lbb_state_t;
endpackage

// File: sim/lbb_exec_checker.sv
// Concurrent checks on the APB pins of the execution slice.
// Assumes one reference clock and the bind statement at the foot of this file.
`timescale 1ns/1ps
module lbb_exec_checker (
	// Clock and reset.
	input wire logic        ref_clk_in,
	input wire logic        arst_n_in,
	// APB pins as seen by the slave.
	input wire logic        psel_in,
	input wire logic        penable_in,
	input wire logic        pwrite_in,
	input wire logic [7:0]  paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic        pready_out,
	input wire logic        pslverr_out
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);
	logic acc_rd;  // Access phase of a read.
	logic bad_adr; // Address outside the ten mapped words.
	assign acc_rd  = psel_in && penable_in && !pwrite_in;
	assign bad_adr = (paddr_in > 8'h24) || (paddr_in[1:0] != 2'h0);
	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	zero_wait_a: assert property (psel_in && penable_in |-> pready_out)
		else $error("access phase without ready");
	err_only_a: assert property (pslverr_out |-> psel_in && penable_in && bad_adr)
		else $error("error response on a mapped or idle bus");
	err_raise_a: assert property (psel_in && penable_in && bad_adr |-> pslverr_out)
		else $error("unmapped access answered without error");
	unmapped_zero_a: assert property (acc_rd && bad_adr |-> prdata_out == 32'h0)
		else $error("unmapped read returned data");
	w_width_a: assert property (acc_rd && paddr_in == 8'h08 |-> prdata_out[31:8] == 24'h0)
		else $error("working register wider than a byte");
	bank_width_a: assert property (acc_rd && paddr_in == 8'h0c |-> prdata_out[31:4] == 28'h0)
		else $error("bank select wider than four bits");
	flag_bits_a: assert property (acc_rd && paddr_in == 8'h10 |-> (prdata_out & ~32'h15) == 32'h0)
		else $error("unknown status flag bit set");
	pc_even_a: assert property (acc_rd && paddr_in == 8'h14 |-> prdata_out[0] == 1'b0)
		else $error("program counter odd");
	cyc_count_a: assert property (acc_rd && paddr_in == 8'h24 |-> prdata_out[5:4] != 2'h3)
		else $error("instruction cycle count out of range");
	// Main scenarios reached.
	cover property (acc_rd && paddr_in == 8'h24 && prdata_out[5:4] == 2'h2);
	cover property (pslverr_out);
	cover property (psel_in && penable_in && pwrite_in && paddr_in == 8'h04);
endmodule // lbb_exec_checker

bind lbb_exec lbb_exec_checker i_lbb_exec_checker (.ref_clk_in, .arst_n_in, .psel_in,
	.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out);

// File: sim/tb_top.sv
// Self-checking bench for the execution slice, driven only over APB.
// Assumes the package and the bound checker are compiled before it.
`timescale 1ns/1ps
module tb_top;
	import lbb_pkg::*;
	// ------------------------------------------------------------------
	// Pins, counters and random state
	// ------------------------------------------------------------------
	logic        ref_clk_in      = 1'b0;
	logic        arst_n_in       = 1'b0;
	logic        psel_in         = 1'b0;
	logic        penable_in      = 1'b0;
	logic        pwrite_in       = 1'b0;
	logic [7:0]  paddr_in        = 8'h00;
	logic [31:0] pwdata_in       = 32'h0;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	int          bad_count       = 0;
	int          samples_checked = 0;
	logic [31:0] seed            = 32'hed82; // Fixed so that runs repeat.
	logic [31:0] q;                          // Last read data.
	logic        e;                          // Last error response.
	lbb_exec i_lbb_exec (.ref_clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out);
	// Free-running 50 MHz clock.
	always #10 ref_clk_in = ~ref_clk_in;
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected data address of a file operand.
	function automatic logic [11:0] ea(logic [7:0] f, logic a, logic x, logic [3:0] b,
		logic [11:0] ix);
		if (a)
			return {b, f};
		if (f <= 8'h5f)
			return x ? ix + {4'h0, f} : {4'h0, f};
		return {4'hf, f};
	endfunction
	// Expected flags after an AND: carry kept, zero and negative from the result.
	function automatic logic [31:0] fx(logic [31:0] fl, logic [7:0] r);
		return {27'h0, r[7], 1'b0, r == 8'h00, 1'b0, fl[0]};
	endfunction
	// One APB transfer; waits for ready, takes data at that same edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do
		begin
			@(posedge ref_clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 64);
		// A slave that never answers is a failure, not a silent pass.
		if (pready_out !== 1'b1)
		begin
			bad_count++;
			$display("unexpected at %0t: no ready from the slave", $time);
		end
		q = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Issue one instruction, then poll busy; q ends as the execution status.
	task automatic run(input logic [15:0] op);
		int n;
		apb(1'b1, LBB_OFS_INSTR, {16'h0, op});
		n = 0;
		do
		begin
			apb(1'b0, LBB_OFS_XSTAT, 32'h0);
			n++;
		end
		while (q[0] !== 1'b0 && n < 20);
		// An instruction that never finishes counts as a mismatch.
		if (q[0] !== 1'b0)
		begin
			bad_count++;
			$display("unexpected at %0t: instruction still busy", $time);
		end
	endtask
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog at 20000 cycles, well beyond the about 1350 the tests need.
	initial
	begin
		#400000;
		bad_count++;
		summarize();
	end
	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		logic [7:0]  w, k, m, f, n;
		logic [3:0]  b;
		logic [11:0] ix;
		logic [31:0] pc, fl;
		int          i;
		repeat (5) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		apb(1'b0, LBB_OFS_PC, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		chk({q[31:1], e}, 32'h1);
		$display("reset and map test done");
		// An opcode outside the slice runs as a one-cycle no-op and is flagged.
		run(16'hffff);
		chk(32'(q[5:0]), 32'h12);
		$display("illegal opcode test done");
		// Literal AND, the first with an all-zero literal.
		for (i = 0; i < 6; i++)
		begin
			w = 8'(rnd());
			k = (i == 0) ? 8'h00 : 8'(rnd());
			fl = rnd() & 32'h15;
			apb(1'b1, LBB_OFS_WREG, 32'(w));
			apb(1'b1, LBB_OFS_FLAGS, fl);
			run({LBB_OP_AND_LIT, k});
			chk(32'(q[5:0]), 32'h10);
			apb(1'b0, LBB_OFS_WREG, 32'h0);
			chk(q, 32'(w & k));
			apb(1'b0, LBB_OFS_FLAGS, 32'h0);
			chk(q, fx(fl, w & k));
		end
		$display("literal test done");
		// File AND then bit clear, with both sides of the 5fh split.
		for (i = 0; i < 16; i++)
		begin
			w = 8'(rnd());
			m = 8'(rnd());
			k = 8'(rnd());
			b = 4'(rnd());
			ix = 12'(rnd());
			f = (i < 4) ? 8'(i * 32'h60 + 32'h5f) : 8'(rnd());
			fl = rnd() & 32'h15;
			apb(1'b1, LBB_OFS_CTRL, 32'(k[2]));
			apb(1'b1, LBB_OFS_BANK, 32'(b));
			apb(1'b1, LBB_OFS_INDEX, 32'(ix));
			apb(1'b1, LBB_OFS_WREG, 32'(w));
			apb(1'b1, LBB_OFS_FLAGS, fl);
			apb(1'b1, LBB_OFS_MADDR, 32'(ea(f, k[0], k[2], b, ix)));
			apb(1'b1, LBB_OFS_MDATA, 32'(m));
			run({LBB_OP_AND_FILE, k[1], k[0], f});
			apb(1'b0, LBB_OFS_WREG, 32'h0);
			chk(q, 32'(k[1] ? w : w & m));
			apb(1'b0, LBB_OFS_MDATA, 32'h0);
			chk(q, 32'(k[1] ? w & m : m));
			apb(1'b0, LBB_OFS_FLAGS, 32'h0);
			fl = fx(fl, w & m);
			chk(q, fl);
			m = 8'(rnd()) | (8'h01 << i[2:0]);
			apb(1'b1, LBB_OFS_MDATA, 32'(m));
			run({LBB_OP_BIT_CLR, i[2:0], k[0], f});
			apb(1'b0, LBB_OFS_MDATA, 32'h0);
			chk(q, 32'(m & ~(8'h01 << i[2:0])));
			apb(1'b0, LBB_OFS_FLAGS, 32'h0);
			chk(q, fl);
		end
		$display("file test done");
		// Branches on carry and negative, both outcomes, offset extremes first.
		for (i = 0; i < 12; i++)
		begin
			n = (i < 4) ? 8'h80 : (i < 8) ? 8'h7f : 8'(rnd());
			pc = rnd() & 32'h1ffffe;
			fl = rnd() & 32'h15;
			fl[i[0] ? 4 : 0] = i[1];
			apb(1'b1, LBB_OFS_PC, pc);
			apb(1'b1, LBB_OFS_FLAGS, fl);
			run({i[0] ? LBB_OP_BR_NEG : LBB_OP_BR_CARRY, n});
			chk(32'(q[5:4]), i[1] ? 32'h2 : 32'h1);
			apb(1'b0, LBB_OFS_PC, 32'h0);
			chk(q, (pc + 32'h2 + (i[1] ? {{23{n[7]}}, n, 1'b0} : 32'h0)) & 32'h1fffff);
			apb(1'b0, LBB_OFS_FLAGS, 32'h0);
			chk(q, fl);
		end
		$display("branch test done");
		summarize();
	end
endmodule // tb_top
